/* logic/uart_afc_pkg.sv */
// shared constants and carriers for the uart auto flow control block
package uart_afc_pkg;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned FIFO_DEPTH  = 32;
	localparam int unsigned LVL_W       = 6;
	// modem control bit positions
	localparam int unsigned MCR_RTS_BIT = 1;
	localparam int unsigned MCR_ARTS    = 6;
	localparam int unsigned MCR_ACTS    = 7;
	// interrupt enable bit positions
	localparam int unsigned IER_MS_BIT  = 3;
	localparam int unsigned IER_CTS_BIT = 7;
	// reset values
	localparam logic [7:0]  MCR_RESET   = 8'h00;
	localparam logic [7:0]  IER_RESET   = 8'h00;
	// receive trigger levels in bytes, per trigger code
	localparam logic [5:0]  TRIG_LVL0   = 6'h01;
	localparam logic [5:0]  TRIG_LVL1   = 6'h04;
	localparam logic [5:0]  TRIG_LVL2   = 6'h08;
	localparam logic [5:0]  TRIG_LVL3   = 6'h0e;
	// serial timing: cycles per bit, fixed small default
	localparam logic [7:0]  BIT_CYCLES  = 8'h10;
	localparam logic [3:0]  FRAME_BITS  = 4'h9;

	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} tx_state_e;

	typedef struct packed
	{
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_delta_s;
endpackage : uart_afc_pkg

/* logic/afc_fifo.sv */
// receive fifo with valid/ready on both sides and fill level
`timescale 1ns/1ps
module afc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// fill side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// drain side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	// status
	output logic [$clog2(DEPTH):0]        level
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      cnt;
	logic [AW-1:0]    next_wptr;
	logic [AW-1:0]    next_rptr;
	logic [AW:0]      next_cnt;
	logic             push;
	logic             pop;

	always_comb
	begin
		push      = in_valid && (cnt != DEPTH[AW:0]);
		pop       = out_ready && (cnt != '0);
		next_wptr = push ? wptr + 1'b1 : wptr;
		next_rptr = pop ? rptr + 1'b1 : rptr;
		next_cnt  = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wptr <= '0;
			rptr <= '0;
			cnt  <= '0;
		end
		else
		begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			cnt  <= next_cnt;
		end
		if (push)
			mem[wptr] <= in_data;
	end

	assign in_ready  = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != '0);
	assign out_data  = mem[rptr];
	assign level     = cnt;
endmodule : afc_fifo

/* logic/uart_auto_flow_control.sv */
// uart rts/cts auto flow control with receive fifo and gated transmitter
// Operation
// - auto_rts_enable hands rts_out to receive fifo logic, not software.
// - rts_out goes high once fill reaches the trigger level.
// - rts_out returns low once fill drops to the next lower level.
// - trigger code 2: release at eight bytes, reassert at four.
// - one more character after rts_out high is still stored.
// - auto_rts off: rts_out follows the software rts control bit.
// - auto_rts on: rts control bit mirrors rts_out, writes ignored.
// - auto_cts on: cts_in sampled before each byte, start only if low.
// - cts high: finish character, idle at 1, resume with start bit.
// - delta cts always set; with auto_cts on, interrupt only with cts interrupt enable.
// - auto_rts_enable is modem control bit 6, resets to 0.
`timescale 1ns/1ps
module uart_auto_flow_control (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// software settings
	input  wire logic                  mcr_we,
	input  wire logic [7:0]            mcr_wdata,
	input  wire logic                  ier_we,
	input  wire logic [7:0]            ier_wdata,
	input  wire logic [1:0]            rx_trigger,
	input  wire logic                  msr_read,
	output logic [7:0]                 modem_control_reg,
	output logic [7:0]                 interrupt_enable_reg,
	output logic [3:0]                 modem_status_reg,
	output logic                       modem_irq,
	// receive characters from the receiver
	input  wire logic                  rx_valid,
	input  wire logic [7:0]            rx_data,
	output logic                       rx_ready,
	// rx_buffer_reg read side
	input  wire logic                  rbr_read,
	output logic                       rbr_valid,
	output logic [7:0]                 rx_buffer_reg,
	output logic [5:0]                 rx_level,
	// transmit bytes in
	input  wire logic                  tx_valid,
	input  wire logic [7:0]            tx_data,
	output logic                       tx_ready,
	// modem pins
	input  wire logic                  cts_in,
	input  wire logic                  dsr_in,
	input  wire logic                  dcd_in,
	input  wire logic                  ri_in,
	output logic                       rts_out,
	output logic                       txd
);
	// ==========================================================
	// pin synchronisers
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [3:0] pin_prev;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin_meta <= 4'hf;
			pin_sync <= 4'hf;
			pin_prev <= 4'hf;
		end
		else
		begin
			pin_meta <= {dcd_in, ri_in, dsr_in, cts_in};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	wire logic cts_s = pin_sync[0];

	// ==========================================================
	// receive fifo
	logic       f_in_ready;
	logic       f_out_valid;
	logic [7:0] f_out_data;
	logic [5:0] f_level;
	logic [5:0] next_fill;
	logic       next_rx_ready;
	always_comb
	begin
		// ready leaves a flop, so it is judged on the fill after this edge
		next_fill     = f_level
			+ {5'h00, rx_valid && f_in_ready}
			- {5'h00, rbr_read && f_out_valid};
		next_rx_ready = (next_fill != 6'(uart_afc_pkg::FIFO_DEPTH));
	end
	afc_fifo #(
		.WIDTH (uart_afc_pkg::DATA_W),
		.DEPTH (uart_afc_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (rx_valid),
		.in_ready  (f_in_ready),
		.in_data   (rx_data),
		.out_valid (f_out_valid),
		.out_ready (rbr_read),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	// ==========================================================
	// control registers and auto-rts
	logic [7:0] next_mcr;
	logic [7:0] next_ier;
	logic       next_rts;
	logic [5:0] trig_hi;
	logic [5:0] trig_lo;
	logic       arts;
	always_comb
	begin
		arts = modem_control_reg[uart_afc_pkg::MCR_ARTS];
		case (rx_trigger)
			2'd0:
			begin
				trig_hi = uart_afc_pkg::TRIG_LVL0;
				trig_lo = 6'h00;
			end
			2'd1:
			begin
				trig_hi = uart_afc_pkg::TRIG_LVL1;
				trig_lo = uart_afc_pkg::TRIG_LVL0;
			end
			2'd2:
			begin
				trig_hi = uart_afc_pkg::TRIG_LVL2;
				trig_lo = uart_afc_pkg::TRIG_LVL1;
			end
			default:
			begin
				trig_hi = uart_afc_pkg::TRIG_LVL3;
				trig_lo = uart_afc_pkg::TRIG_LVL2;
			end
		endcase
		next_mcr = mcr_we ? mcr_wdata : modem_control_reg;
		// the written value decides, so a write that ends auto-rts lands
		if (next_mcr[uart_afc_pkg::MCR_ARTS])
			next_mcr[uart_afc_pkg::MCR_RTS_BIT] = ~rts_out;
		next_ier = ier_we ? ier_wdata : interrupt_enable_reg;
		next_rts = rts_out;
		if (arts)
		begin
			// rts is the active-low level on the pin
			if (f_level >= trig_hi)
				next_rts = 1'b1;
			else if (f_level <= trig_lo)
				next_rts = 1'b0;
		end
		else
			next_rts = ~next_mcr[uart_afc_pkg::MCR_RTS_BIT];
	end

	// ==========================================================
	// modem status deltas and interrupt
	uart_afc_pkg::modem_delta_s delta;
	uart_afc_pkg::modem_delta_s next_delta;
	logic next_irq;
	logic acts;
	always_comb
	begin
		acts = modem_control_reg[uart_afc_pkg::MCR_ACTS];
		next_delta = msr_read ? '0 : delta;
		// set wins over a read clear
		if (pin_sync[0] != pin_prev[0])
			next_delta.cts = 1'b1;
		if (pin_sync[1] != pin_prev[1])
			next_delta.dsr = 1'b1;
		// ring ends when its active-low pin rises
		if (pin_sync[2] && !pin_prev[2])
			next_delta.ri = 1'b1;
		if (pin_sync[3] != pin_prev[3])
			next_delta.dcd = 1'b1;
		next_irq = next_ier[uart_afc_pkg::IER_MS_BIT]
			&& (next_delta.dcd || next_delta.ri || next_delta.dsr
			|| (next_delta.cts
			&& (!next_mcr[uart_afc_pkg::MCR_ACTS]
			|| next_ier[uart_afc_pkg::IER_CTS_BIT])));
	end

	// ==========================================================
	// transmitter with cts gating
	uart_afc_pkg::tx_state_e tx_state;
	uart_afc_pkg::tx_state_e next_tx_state;
	logic [7:0] tx_shift_register;
	logic [7:0] next_tsr;
	logic [7:0] bit_cnt;
	logic [7:0] next_bit_cnt;
	logic [3:0] bit_idx;
	logic [3:0] next_bit_idx;
	logic       next_txd;
	logic       next_tx_ready;
	logic       bit_end;
	always_comb
	begin
		next_tx_state = tx_state;
		next_tsr      = tx_shift_register;
		next_bit_idx  = bit_idx;
		next_txd      = txd;
		bit_end       = (bit_cnt == uart_afc_pkg::BIT_CYCLES - 8'h01);
		next_bit_cnt  = bit_end ? 8'h00 : bit_cnt + 8'h01;
		next_tx_ready = 1'b0;
		case (tx_state)
			uart_afc_pkg::TX_IDLE:
			begin
				next_txd     = 1'b1;
				next_bit_cnt = 8'h00;
				// cts is checked only here, before each byte
				if (tx_valid && !tx_ready && (!acts || !cts_s))
				begin
					next_tsr      = tx_data;
					next_tx_ready = 1'b1;
					next_txd      = 1'b0;
					next_tx_state = uart_afc_pkg::TX_START;
				end
			end
			uart_afc_pkg::TX_START:
				if (bit_end)
				begin
					next_txd      = tx_shift_register[0];
					next_tsr      = {1'b0, tx_shift_register[7:1]};
					next_bit_idx  = 4'h1;
					next_tx_state = uart_afc_pkg::TX_DATA;
				end
			uart_afc_pkg::TX_DATA:
				if (bit_end)
				begin
					if (bit_idx == uart_afc_pkg::FRAME_BITS - 4'h1)
					begin
						next_txd      = 1'b1;
						next_tx_state = uart_afc_pkg::TX_STOP;
					end
					else
					begin
						next_txd     = tx_shift_register[0];
						next_tsr     = {1'b0, tx_shift_register[7:1]};
						next_bit_idx = bit_idx + 4'h1;
					end
				end
			uart_afc_pkg::TX_STOP:
				if (bit_end)
					next_tx_state = uart_afc_pkg::TX_IDLE;
			default:
				next_tx_state = uart_afc_pkg::TX_IDLE;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			modem_control_reg    <= uart_afc_pkg::MCR_RESET;
			interrupt_enable_reg <= uart_afc_pkg::IER_RESET;
			rts_out              <= 1'b1;
			delta                <= '0;
			modem_status_reg     <= 4'h0;
			modem_irq            <= 1'b0;
			tx_state             <= uart_afc_pkg::TX_IDLE;
			tx_shift_register    <= 8'h00;
			bit_cnt              <= 8'h00;
			bit_idx              <= 4'h0;
			txd                  <= 1'b1;
			tx_ready             <= 1'b0;
			rbr_valid            <= 1'b0;
			rx_buffer_reg        <= 8'h00;
			rx_level             <= 6'h00;
			rx_ready             <= 1'b1;
		end
		else
		begin
			modem_control_reg    <= next_mcr;
			interrupt_enable_reg <= next_ier;
			rts_out              <= next_rts;
			delta                <= next_delta;
			modem_status_reg     <= next_delta;
			modem_irq            <= next_irq;
			tx_state             <= next_tx_state;
			tx_shift_register    <= next_tsr;
			bit_cnt              <= next_bit_cnt;
			bit_idx              <= next_bit_idx;
			txd                  <= next_txd;
			tx_ready             <= next_tx_ready;
			rbr_valid            <= f_out_valid;
			rx_buffer_reg        <= f_out_data;
			rx_level             <= f_level;
			rx_ready             <= next_rx_ready;
		end
	end
endmodule : uart_auto_flow_control

/* dv/afc_monitor.sv */
// assertion checker for the uart auto flow control block
`timescale 1ns/1ps
module afc_monitor (
	// clock and reset
	input wire logic       clk,
	input wire logic       srst,
	// settings and status
	input wire logic [7:0] modem_control_reg,
	input wire logic [7:0] interrupt_enable_reg,
	input wire logic [3:0] modem_status_reg,
	input wire logic       modem_irq,
	input wire logic [1:0] rx_trigger,
	input wire logic [5:0] rx_level,
	input wire logic       msr_read,
	// pins and transmit handshake
	input wire logic       cts_in,
	input wire logic       rts_out,
	input wire logic       tx_ready,
	input wire logic       txd
);
	logic [7:0] m;
	logic [7:0] e;
	logic [3:0] s;
	logic       irq_exp;
	assign m = modem_control_reg;
	assign e = interrupt_enable_reg;
	assign s = modem_status_reg;
	assign irq_exp = e[3] && (|s[3:1] || (s[0] && (!m[7] || e[7])));
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================
	// flow control and interrupt relations
	a_rts_at_eight:
	assert property (m[6] && rx_trigger == 2'h2 && rx_level == 6'h08
		|-> ##[0:2] rts_out) else $error("rts not released");
	a_rts_at_four:
	assert property (m[6] && rx_trigger == 2'h2 && rx_level <= 6'h04
		|-> ##[0:2] !rts_out) else $error("rts not resumed");
	a_rts_soft:
	assert property ((!m[6] && $stable(m)) [*3] |-> rts_out == !m[1])
		else $error("rts not from control bit");
	a_rts_mirror:
	assert property ((m[6] && $stable(rts_out)) [*3] |-> m[1] == !rts_out)
		else $error("control bit not mirrored");
	a_cts_blocks:
	assert property ((m[7] && cts_in) [*5] |-> !tx_ready)
		else $error("byte taken while cts high");
	a_start_bit:
	assert property ($rose(tx_ready) |-> !txd [*8])
		else $error("no start bit");
	a_ready_pulse:
	assert property ($rose(tx_ready) |=> !tx_ready [*8])
		else $error("ready not a pulse");
	a_cts_delta:
	assert property ($changed(cts_in) && !msr_read |-> ##[1:4] s[0])
		else $error("delta cts missing");
	a_irq_table:
	assert property (($stable(e) && $stable(m) && $stable(s)) [*2]
		|-> modem_irq == irq_exp) else $error("modem irq wrong");
endmodule : afc_monitor

bind uart_auto_flow_control afc_monitor mon (.clk, .srst,
	.modem_control_reg, .interrupt_enable_reg, .modem_status_reg,
	.modem_irq, .rx_trigger, .rx_level, .msr_read, .cts_in, .rts_out,
	.tx_ready, .txd);

/* dv/remote_peer.sv */
// remote uart model: drives cts and decodes the serial output
`timescale 1ns/1ps
module remote_peer (
	// clock
	input  wire logic       clk,
	// serial line and cts request from the bench
	input  wire logic       txd,
	input  wire logic       stop_req,
	// handshake pin and decoded bytes
	output logic            cts_in,
	output logic [7:0]      got,
	output int              n_got
);
	// cts moves on a clock edge, long before any stop bit midpoint
	initial
	begin
		cts_in = 1'b1;
		forever
			@(posedge clk) cts_in <= stop_req;
	end
	initial
	begin
		n_got = 0;
		got = 8'h00;
		forever
		begin
			@(negedge txd);
			repeat (24) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				got[i] = txd;
				repeat (16) @(posedge clk);
			end
			n_got++;
		end
	end
endmodule : remote_peer

/* dv/uart_auto_flow_control_bench.sv */
// self-checking bench for the uart auto flow control block
`timescale 1ns/1ps
module uart_auto_flow_control_bench;
	logic clk = 1'b0, srst = 1'b1;
	logic mcr_we = 1'b0, ier_we = 1'b0, msr_read = 1'b0;
	logic [7:0] mcr_wdata = 8'h00, ier_wdata = 8'h00;
	logic [1:0] rx_trigger = 2'h2;
	logic rx_valid = 1'b0, rbr_read = 1'b0, tx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00, tx_data = 8'h00;
	logic dsr_in = 1'b1, dcd_in = 1'b1, ri_in = 1'b1, stop_req = 1'b1;
	logic [7:0] modem_control_reg, interrupt_enable_reg, rx_buffer_reg, got;
	logic [3:0] modem_status_reg;
	logic [5:0] rx_level;
	logic modem_irq, rx_ready, rbr_valid, tx_ready, cts_in, rts_out, txd;
	int n_got;
	int failures = 0, samples_checked = 0;
	uart_auto_flow_control DUT (.clk, .srst, .mcr_we, .mcr_wdata, .ier_we,
		.ier_wdata, .rx_trigger, .msr_read, .modem_control_reg,
		.interrupt_enable_reg, .modem_status_reg, .modem_irq, .rx_valid,
		.rx_data, .rx_ready, .rbr_read, .rbr_valid, .rx_buffer_reg,
		.rx_level, .tx_valid, .tx_data, .tx_ready, .cts_in, .dsr_in,
		.dcd_in, .ri_in, .rts_out, .txd);
	remote_peer peer (.clk, .txd, .stop_req, .cts_in, .got, .n_got);
	initial forever #50 clk = ~clk;
	// ==========================================
	// shared tasks
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic chk(input bit ok, input string msg);
		samples_checked++;
		if (!ok)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic wr(input bit ier, input logic [7:0] v);
		mcr_wdata = v;
		ier_wdata = v;
		mcr_we = !ier;
		ier_we = ier;
		tick(1);
		mcr_we = 1'b0;
		ier_we = 1'b0;
		tick(3);
	endtask : wr
	task automatic pulse(ref logic p);
		p = 1'b1;
		tick(1);
		p = 1'b0;
		tick(3);
	endtask : pulse
	task automatic send(input logic [7:0] v);
		tx_data = v;
		tx_valid = 1'b1;
		for (int i = 0; i < 600 && tx_ready !== 1'b1; i++)
			tick(1);
		chk(tx_ready === 1'b1, "byte not taken");
		tx_valid = 1'b0;
	endtask : send
	// ==========================================
	// scenarios
	task automatic t_rts;
		chk(modem_control_reg === 8'h00 && rts_out === 1'b1, "reset");
		wr(0, 8'h02);
		chk(rts_out === 1'b0, "soft rts");
		wr(0, 8'h40);
		for (int i = 1; i <= 9; i++)
		begin
			rx_data = 8'(i);
			chk(rx_ready === 1'b1, "fifo refused");
			pulse(rx_valid);
			chk(rts_out === (i >= 8), "rts on fill");
			chk(modem_control_reg[1] === (i < 8), "mirror");
		end
		chk(rx_level === 6'h09, "extra char lost");
		wr(0, 8'h42);
		chk(rts_out === 1'b1 && modem_control_reg[1] === 1'b0, "ro bit");
		chk(rbr_valid === 1'b1, "fifo empty");
		for (int i = 1; i <= 9; i++)
		begin
			chk(rx_buffer_reg === 8'(i), "fifo order");
			pulse(rbr_read);
			chk(rts_out === (9 - i > 4), "rts on drain");
		end
		chk(rbr_valid === 1'b0, "fifo not empty");
		wr(0, 8'h00);
		chk(rts_out === 1'b1, "soft rts off");
	endtask : t_rts
	task automatic t_cts;
		int n;
		wr(0, 8'h80);
		n = n_got;
		tx_data = 8'ha5;
		tx_valid = 1'b1;
		tick(200);
		chk(txd === 1'b1 && n_got == n, "sent under cts high");
		stop_req = 1'b0;
		send(8'ha5);
		tick(30);
		stop_req = 1'b1;
		tx_data = 8'h3c;
		tx_valid = 1'b1;
		tick(300);
		chk(n_got == n + 1 && got === 8'ha5 && txd === 1'b1, "stall");
		stop_req = 1'b0;
		send(8'h3c);
		tick(170);
		chk(n_got == n + 2 && got === 8'h3c, "resume");
		wr(0, 8'h00);
		stop_req = 1'b1;
		send(8'h96);
		tick(170);
		chk(n_got == n + 3 && got === 8'h96, "free send");
	endtask : t_cts
	task automatic t_irq;
		wr(1, 8'h08);
		chk(interrupt_enable_reg === 8'h08, "ier write");
		wr(0, 8'h80);
		pulse(msr_read);
		stop_req = 1'b0;
		tick(6);
		chk(modem_status_reg[0] === 1'b1 && modem_irq === 1'b0, "quiet");
		wr(1, 8'h88);
		chk(modem_irq === 1'b1, "cts irq");
		wr(1, 8'h08);
		wr(0, 8'h00);
		chk(modem_irq === 1'b1, "cts irq plain");
		wr(1, 8'h00);
		pulse(msr_read);
		dsr_in = 1'b0;
		tick(6);
		chk(modem_irq === 1'b0, "irq masked");
		wr(1, 8'h08);
		chk(modem_irq === 1'b1 && modem_status_reg[1] === 1'b1, "dsr");
		pulse(msr_read);
		ri_in = 1'b0;
		tick(6);
		chk({modem_status_reg, modem_irq} === 5'h00, "ri lead");
		ri_in = 1'b1;
		tick(6);
		chk({modem_status_reg, modem_irq} === 5'h09, "ri trail");
		pulse(msr_read);
		dcd_in = 1'b0;
		tick(6);
		chk({modem_status_reg, modem_irq} === 5'h11, "dcd");
	endtask : t_irq
	// ==========================================
	// run control
	task automatic close_out;
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	initial
	begin
		tick(3);
		srst = 1'b0;
		tick(1);
		t_rts();
		t_cts();
		t_irq();
		close_out();
	end
	initial
	begin
		#2_000_000;
		failures++;
		close_out();
	end
endmodule : uart_auto_flow_control_bench
